// ===== rtl/spi_host_port.sv
// host-facing spi port with buffered byte streams and io line three
`timescale 1ns/10ps

// Operation
// R1 - in slave role io line three drives high while transmit data waits
// R2 - outside slave role io line three stays an ordinary general io line
// R3 - master reads pending data when the data pending line is high
// R4 - reset low resets all logic; operation resumes after release
// R5 - miso is data input as master, driven data output as slave; the port drives it only while selected
// R6 - mosi is driven data output as master, sampled input as slave
// R7 - slave select is active low; driven as master, input as slave
// R8 - serial clock made here as master, taken as input as slave
// R9 - clear-to-send output low only while receive buffer has room
// R10 - data pending drops once the last queued byte is clocked out
module spi_host_port
    import spi_port_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic slaveMode,
    // transmit byte stream from the module core
    input wire logic [DATA_W-1:0] txData,
    input wire logic txValid,
    output logic txReady,
    // receive byte stream towards the module core
    output logic [DATA_W-1:0] rxData,
    output logic rxValid,
    input wire logic rxReady,
    // spi pins, each as input, output and enable
    input wire logic misoIn,
    output logic misoOut,
    output logic misoOe,
    input wire logic mosiIn,
    output logic mosiOut,
    output logic mosiOe,
    input wire logic ssNIn,
    output logic ssNOut,
    output logic ssNOe,
    input wire logic sclkIn,
    output logic sclkOut,
    output logic sclkOe,
    // flow control towards the host
    output logic hostCtsN,
    // general io line three, pin side and core side
    input wire logic generalIoLineThreeIn,
    output logic generalIoLineThreeOut,
    output logic generalIoLineThreeOe,
    input wire logic gpioOut,
    input wire logic gpioOe,
    output logic gpioIn,
    output logic dataPendingFlag
);

    port_state_t st;
    port_state_t next_st;

    // reset record: idle, master role, select and its history high
    localparam port_state_t RESET_ST = '{
        fsm: ST_IDLE,
        slaveRole: 1'b0, // master role until idle samples slaveMode
        sclkSync: '0, // serial clock idles low in mode 0
        ssSync: '1, // select idles high, so no false assert
        mosiSync: '0,
        misoSync: '0,
        gpioSync: '0,
        sclkPrev: 1'b0,
        ssPrev: 1'b1,
        txShift: '0,
        rxShift: '0,
        bitCount: FIRST_BIT,
        loaded: 1'b0,
        divCount: DIV_ZERO,
        sclkLevel: 1'b0,
        ssLevel: 1'b1,
        txMem: '0,
        txHead: 1'b0,
        txCount: BUF_EMPTY,
        rxMem: '0,
        rxHead: 1'b0,
        rxCount: BUF_EMPTY
    };

    // strobes and buffer indices of the current cycle
    logic sclkRise;
    logic sclkFall;
    logic ssAssert;
    logic ssRelease;
    logic txPush;
    logic txPop;
    logic rxPush;
    logic rxPop;
    logic [DATA_W-1:0] rxByte;
    logic txTail;
    logic rxTail;

    // edges seen on the synchronised link inputs
    assign sclkRise = st.sclkSync[1] & ~st.sclkPrev;
    assign sclkFall = ~st.sclkSync[1] & st.sclkPrev;
    assign ssAssert = ~st.ssSync[1] & st.ssPrev;
    assign ssRelease = st.ssSync[1] & ~st.ssPrev;

    // buffer handshakes on the core side
    assign txReady = (st.txCount != BUF_DEPTH);
    assign txPush = txValid & txReady;
    assign rxValid = (st.rxCount != BUF_EMPTY);
    assign rxPop = rxValid & rxReady;
    assign rxData = st.rxMem[st.rxHead];
    assign txTail = st.txHead ^ st.txCount[0];
    assign rxTail = st.rxHead ^ st.rxCount[0];

    // flow control: high only when receive buffer is full
    assign hostCtsN = (st.rxCount == BUF_DEPTH); // see R9

    // pending flag from queued or loaded transmit bytes
    assign dataPendingFlag = st.slaveRole &&
        (st.txCount != BUF_EMPTY); // see R1, see R10, see R3

    // io line three: flag in slave role, plain io otherwise
    always_comb begin
        if (st.slaveRole) begin
            generalIoLineThreeOut = dataPendingFlag; // see R1
            generalIoLineThreeOe = 1'b1;
        end else begin
            generalIoLineThreeOut = gpioOut; // see R2
            generalIoLineThreeOe = gpioOe;
        end
    end
    // core reads the pin only after two flops
    assign gpioIn = st.gpioSync[1];

    // pin drive per role
    always_comb begin
        if (st.slaveRole) begin
            misoOut = st.txShift[DATA_W-1]; // see R5
            misoOe = (st.fsm == ST_SLAVE);
            mosiOut = 1'b0; // see R6
            mosiOe = 1'b0;
            ssNOut = 1'b1; // see R7
            ssNOe = 1'b0;
            sclkOut = 1'b0; // see R8
            sclkOe = 1'b0;
        end else begin
            misoOut = 1'b0; // see R5
            misoOe = 1'b0;
            mosiOut = st.txShift[DATA_W-1]; // see R6
            mosiOe = 1'b1;
            ssNOut = st.ssLevel; // see R7
            ssNOe = 1'b1;
            sclkOut = st.sclkLevel; // see R8
            sclkOe = 1'b1;
        end
    end

    // next state of the whole port
    always_comb begin
        next_st = st;
        txPop = 1'b0;
        rxPush = 1'b0;
        rxByte = st.rxShift;

        // two-stage synchronisers and edge history
        next_st.sclkSync = {st.sclkSync[0], sclkIn};
        next_st.ssSync = {st.ssSync[0], ssNIn};
        next_st.mosiSync = {st.mosiSync[0], mosiIn};
        next_st.misoSync = {st.misoSync[0], misoIn};
        next_st.gpioSync = {st.gpioSync[0], generalIoLineThreeIn};
        next_st.sclkPrev = st.sclkSync[1];
        next_st.ssPrev = st.ssSync[1];

        case (st.fsm)
            ST_IDLE: begin
                // role only changes between transfers
                next_st.slaveRole = slaveMode;
                next_st.sclkLevel = 1'b0;
                next_st.ssLevel = 1'b1;
                next_st.bitCount = FIRST_BIT;
                next_st.divCount = DIV_ZERO;
                if (st.slaveRole && slaveMode && ssAssert) begin
                    // selected by the external master
                    next_st.fsm = ST_SLAVE; // see R7
                    next_st.loaded = (st.txCount != BUF_EMPTY);
                    next_st.txShift = (st.txCount != BUF_EMPTY) ?
                        st.txMem[st.txHead] : '0;
                end else if (!st.slaveRole && !slaveMode &&
                        st.txCount != BUF_EMPTY &&
                        st.rxCount != BUF_DEPTH) begin
                    // master starts a byte when one is queued and the receive buffer has room
                    next_st.fsm = ST_MLOW;
                    next_st.ssLevel = 1'b0; // see R7
                    next_st.loaded = 1'b1;
                    next_st.txShift = st.txMem[st.txHead];
                end
            end
            ST_SLAVE: begin
                if (ssRelease) begin
                    // frame ends; a partial byte is dropped
                    next_st.fsm = ST_IDLE;
                    next_st.loaded = 1'b0;
                    next_st.bitCount = FIRST_BIT;
                end else if (sclkRise) begin
                    // sample mosi on rising clock edge
                    next_st.rxShift = {st.rxShift[DATA_W-2:0],
                        st.mosiSync[1]}; // see R6, see R8
                    next_st.bitCount = st.bitCount + 3'h1;
                    if (st.bitCount == LAST_BIT) begin
                        rxByte = {st.rxShift[DATA_W-2:0], st.mosiSync[1]};
                        rxPush = (st.rxCount != BUF_DEPTH); // see R9
                        txPop = st.loaded; // see R10
                        next_st.loaded = 1'b0;
                    end
                end else if (sclkFall) begin
                    if (st.bitCount == FIRST_BIT) begin
                        // next byte of a longer frame
                        next_st.loaded = (st.txCount != BUF_EMPTY);
                        next_st.txShift = (st.txCount != BUF_EMPTY) ?
                            st.txMem[st.txHead] : '0; // see R5
                    end else begin
                        next_st.txShift = {st.txShift[DATA_W-2:0], 1'b0};
                    end
                end
            end
            ST_MLOW: begin
                // low half of the generated serial clock
                if (st.divCount == DIV_LAST) begin
                    next_st.divCount = DIV_ZERO;
                    next_st.sclkLevel = 1'b1; // see R8
                    next_st.fsm = ST_MHIGH;
                end else begin
                    next_st.divCount = st.divCount + 4'h1;
                end
            end
            ST_MHIGH: begin
                // high half; miso taken just before the fall
                if (st.divCount == DIV_LAST) begin
                    next_st.divCount = DIV_ZERO;
                    next_st.sclkLevel = 1'b0;
                    next_st.rxShift = {st.rxShift[DATA_W-2:0],
                        st.misoSync[1]}; // see R5
                    next_st.txShift = {st.txShift[DATA_W-2:0], 1'b0};
                    next_st.bitCount = st.bitCount + 3'h1;
                    next_st.fsm = (st.bitCount == LAST_BIT) ?
                        ST_MEND : ST_MLOW;
                end else begin
                    next_st.divCount = st.divCount + 4'h1;
                end
            end
            ST_MEND: begin
                // hold select one half period, then release
                if (st.divCount == DIV_LAST) begin
                    next_st.divCount = DIV_ZERO;
                    next_st.ssLevel = 1'b1; // see R7
                    next_st.loaded = 1'b0;
                    rxPush = (st.rxCount != BUF_DEPTH);
                    txPop = st.loaded;
                    next_st.fsm = ST_IDLE;
                end else begin
                    next_st.divCount = st.divCount + 4'h1;
                end
            end
            // an illegal code falls back to idle
            default: begin
                next_st.fsm = ST_IDLE;
            end
        endcase

        // transmit buffer update
        if (txPush) begin
            next_st.txMem[txTail] = txData;
        end
        if (txPop) begin
            next_st.txHead = ~st.txHead;
        end
        if (txPush && !txPop) begin
            next_st.txCount = st.txCount + ONE_WORD;
        end else if (!txPush && txPop) begin
            next_st.txCount = st.txCount - ONE_WORD; // see R10
        end

        // receive buffer update
        if (rxPush) begin
            next_st.rxMem[rxTail] = rxByte;
        end
        if (rxPop) begin
            next_st.rxHead = ~st.rxHead;
        end
        if (rxPush && !rxPop) begin
            next_st.rxCount = st.rxCount + ONE_WORD;
        end else if (!rxPush && rxPop) begin
            next_st.rxCount = st.rxCount - ONE_WORD;
        end
    end

    // state register, frozen while clkEn is low
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= RESET_ST; // see R4
        end else if (clkEn) begin
            st <= next_st;
        end
    end

endmodule : spi_host_port

// ===== inc/spi_port_pkg.sv
// constants, states and state record of the host-facing spi port
package spi_port_pkg;

    // byte and buffer geometry
    localparam int DATA_W = 8;
    localparam int BIT_W = 3;
    localparam logic [BIT_W-1:0] LAST_BIT = 3'h7;
    localparam logic [BIT_W-1:0] FIRST_BIT = 3'h0;
    localparam int CNT_W = 2;
    localparam logic [CNT_W-1:0] BUF_DEPTH = 2'h2;
    localparam logic [CNT_W-1:0] BUF_EMPTY = 2'h0;
    localparam logic [CNT_W-1:0] ONE_WORD = 2'h1;

    // serial clock made when the port is master
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCLK_HALF_NS = 60;
    localparam int HALF_RAW = SCLK_HALF_NS / CLK_PERIOD_NS;
    localparam int HALF_CYC = (HALF_RAW < 1) ? 1 : HALF_RAW;
    localparam int DIV_W = 4;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYC - 1);
    localparam logic [DIV_W-1:0] DIV_ZERO = 4'h0;

    // one-hot sequencer states
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_SLAVE = 5'h02,
        ST_MLOW = 5'h04,
        ST_MHIGH = 5'h08,
        ST_MEND = 5'h10
    } state_e_t;

    // whole state of the port
    typedef struct packed {
        state_e_t fsm;
        logic slaveRole;
        logic [1:0] sclkSync;
        logic [1:0] ssSync;
        logic [1:0] mosiSync;
        logic [1:0] misoSync;
        logic [1:0] gpioSync;
        logic sclkPrev;
        logic ssPrev;
        logic [DATA_W-1:0] txShift;
        logic [DATA_W-1:0] rxShift;
        logic [BIT_W-1:0] bitCount;
        logic loaded;
        logic [DIV_W-1:0] divCount;
        logic sclkLevel;
        logic ssLevel;
        logic [1:0][DATA_W-1:0] txMem;
        logic txHead;
        logic [CNT_W-1:0] txCount;
        logic [1:0][DATA_W-1:0] rxMem;
        logic rxHead;
        logic [CNT_W-1:0] rxCount;
    } port_state_t;

endpackage : spi_port_pkg

// ===== bench/spi_host_port_checker.sv
// assertions on the pins and streams of the spi host port
`timescale 1ns/10ps
module spi_host_port_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sclkOut,
    input wire logic sclkOe,
    input wire logic ssNOut,
    input wire logic ssNOe,
    input wire logic mosiOe,
    input wire logic misoOe,
    input wire logic txReady,
    input wire logic rxValid,
    input wire logic hostCtsN,
    input wire logic generalIoLineThreeOut,
    input wire logic generalIoLineThreeOe,
    input wire logic gpioOut,
    input wire logic gpioOe,
    input wire logic dataPendingFlag
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // line three follows its role
    a_line_pending: assert property (!sclkOe |->
        generalIoLineThreeOe && generalIoLineThreeOut == dataPendingFlag)
        else $error("line three misses pending flag");
    a_line_general: assert property (sclkOe |->
        generalIoLineThreeOut == gpioOut && generalIoLineThreeOe == gpioOe)
        else $error("line three not general io");
    // reset state and pin directions
    a_reset_state: assert property (disable iff (1'b0) !rst_n |->
        ssNOut && sclkOe && !misoOe && txReady && !rxValid)
        else $error("reset state wrong");
    a_pin_roles: assert property (mosiOe == sclkOe &&
        ssNOe == sclkOe && !(sclkOe && misoOe))
        else $error("pin direction wrong");
    // master frame timing
    a_select_lead: assert property ($fell(ssNOut) && ssNOe |->
        !sclkOut [*6] ##1 sclkOut) else $error("select lead wrong");
    a_sclk_high: assert property ($rose(sclkOut) && sclkOe |->
        sclkOut [*6] ##1 !sclkOut) else $error("clock high half wrong");
    // flow control and pending flag
    a_cts_full: assert property (hostCtsN |-> rxValid)
        else $error("cts high with room");
    a_pending_drop: assert property ($fell(dataPendingFlag) &&
        !sclkOe |-> txReady) else $error("flag fell with data held");
endmodule : spi_host_port_checker

bind spi_host_port spi_host_port_checker i_chk (.*);

// ===== bench/spi_host_model.sv
// far-end host: spi master for slave tests, spi slave for master tests
`timescale 1ns/10ps
module spi_host_model (
    input wire logic sclk,
    input wire logic ssN,
    input wire logic mosi,
    input wire logic miso,
    output logic hSclk,
    output logic hSsN,
    output logic hMosi,
    output logic hMiso
);
    logic [7:0] shOut = 8'hA5;
    logic [7:0] shIn = 8'h00;
    initial begin
        hSclk = 1'b0;
        hSsN = 1'b1;
        hMosi = 1'b0;
    end
    // slave side: select loads reply, fall shifts, rise samples
    always @(negedge ssN) shOut = 8'hA5;
    always @(negedge sclk) if (!ssN) shOut = {shOut[6:0], 1'b0};
    always @(posedge sclk) if (!ssN) shIn = {shIn[6:0], mosi};
    assign hMiso = shOut[7] ^ ssN; // released line shows inverse
    // master side: mode 0 frame, clock still outside frames
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        hSsN = 1'b0;
        #62.5;
        for (int i = 7; i >= 0; i--) begin
            hMosi = tx[i];
            #62.5 hSclk = 1'b1;
            rx[i] = miso;
            #62.5 hSclk = 1'b0;
        end
        #62.5 hSsN = 1'b1;
        hMosi = ~hMosi;
        #250;
    endtask : xfer
endmodule : spi_host_model

// ===== bench/spi_host_port_test.sv
// self-checking bench of the spi host port with a host model
`timescale 1ns/10ps
module spi_host_port_test;
    import spi_port_pkg::*;
    logic clock = 1'b0, rst_n = 1'b1, clkEn = 1'b1, slaveMode = 1'b0;
    logic txValid = 1'b0, rxReady = 1'b0, gpioOut = 1'b0, gpioOe = 1'b0;
    logic [DATA_W-1:0] txData = 8'h00, rxData;
    logic txReady, rxValid, misoOut, misoOe, mosiOut, mosiOe, ssNOut, ssNOe;
    logic sclkOut, sclkOe, hostCtsN, l3Out, l3Oe, dataPendingFlag, gpioIn;
    logic hSclk, hSsN, hMosi, hMiso;
    int n_fail = 0, check_count = 0;
    // pin levels from the port's enables, the host model drives otherwise
    wire logic miso = misoOe ? misoOut : hMiso;
    wire logic mosi = mosiOe ? mosiOut : hMosi;
    wire logic ssN = ssNOe ? ssNOut : hSsN;
    wire logic sclk = sclkOe ? sclkOut : hSclk;
    always #5 clock = ~clock;
    spi_host_port i_dut (.clock, .rst_n, .clkEn, .slaveMode, .txData,
        .txValid, .txReady, .rxData, .rxValid, .rxReady, .misoIn(miso),
        .misoOut, .misoOe, .mosiIn(mosi), .mosiOut, .mosiOe, .ssNIn(ssN),
        .ssNOut, .ssNOe, .sclkIn(sclk), .sclkOut, .sclkOe, .hostCtsN,
        .generalIoLineThreeIn(l3Oe ? l3Out : 1'b1),
        .generalIoLineThreeOut(l3Out), .generalIoLineThreeOe(l3Oe),
        .gpioOut, .gpioOe, .gpioIn, .dataPendingFlag);
    spi_host_model i_host (.sclk, .ssN, .mosi, .miso, .hSclk, .hSsN,
        .hMosi, .hMiso);
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t: %h vs %h", $time, seen, exp);
        end
    endtask : check
    // offer one byte, held until an edge that sees txReady
    task automatic push(input logic [7:0] b);
        txData <= b;
        txValid <= 1'b1;
        @(negedge clock);
        while (txReady !== 1'b1) @(negedge clock);
        @(posedge clock);
    endtask : push
    // take one received byte, then settle for a look
    task automatic pop_one;
        @(posedge clock);
        rxReady <= 1'b1;
        @(posedge clock);
        rxReady <= 1'b0;
        @(negedge clock);
    endtask : pop_one
    task automatic reset_values;
        @(negedge clock);
        check({ssNOut, sclkOe, misoOe, txReady}, 4'hD);
        check({hostCtsN, l3Oe}, 2'h0);
    endtask : reset_values
    // slave role: two queued bytes, full receive side, empty send
    task automatic slave_path;
        logic [7:0] r;
        @(posedge clock);
        slaveMode <= 1'b1;
        repeat (6) @(posedge clock);
        push(8'h3C);
        push(8'hC3);
        txValid <= 1'b0;
        @(negedge clock);
        check({l3Out, l3Oe, txReady}, 3'h6);
        check({mosiOe, sclkOe, ssNOe}, 3'h0);
        i_host.xfer(8'h5A, r);
        check(r, 8'h3C);
        i_host.xfer(8'h96, r);
        check(r, 8'hC3);
        repeat (8) @(negedge clock);
        check({dataPendingFlag, l3Out, hostCtsN}, 3'h1);
        check(rxData, 8'h5A);
        pop_one();
        check(rxData, 8'h96);
        check(hostCtsN, 1'b0);
        // host sends again only once clear-to-send is low
        i_host.xfer(8'h77, r);
        check(r, 8'h00);
        @(negedge clock);
        check(hostCtsN, 1'b1);
        pop_one();
        check(rxData, 8'h77);
        pop_one();
        check({rxValid, hostCtsN}, 2'h0);
    endtask : slave_path
    // reset in mid-run, then one master frame
    task automatic master_path;
        int n;
        @(posedge clock);
        push(8'h11);
        txValid <= 1'b0;
        rst_n <= 1'b0;
        slaveMode <= 1'b0;
        gpioOut <= 1'b1;
        gpioOe <= 1'b1;
        @(negedge clock);
        check({dataPendingFlag, txReady}, 2'h1);
        @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(negedge clock);
        check({l3Out, l3Oe, gpioIn}, 3'h7);
        @(posedge clock);
        push(8'hE1);
        txValid <= 1'b0;
        n = 0;
        while (rxValid !== 1'b1 && n < 400) begin
            @(negedge clock);
            n++;
        end
        check(rxValid, 1'b1);
        check(rxData, 8'hA5);
        check(i_host.shIn, 8'hE1);
        check(ssNOut, 1'b1);
    endtask : master_path
    task automatic print_verdict;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    // reset, scenarios, verdict
    initial begin
        rst_n <= 1'b0; // falls at time 0 so the async branch acts
        repeat (4) @(posedge clock);
        reset_values();
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        slave_path();
        master_path();
        print_verdict();
    end
    // watchdog against a hang
    initial begin
        #100000;
        n_fail++;
        print_verdict();
    end
endmodule : spi_host_port_test
